/* timer3_auto_reload_timer.sv */
// AHB-Lite timer with a 16-bit auto-reload mode and a split mode of two 8-bit counters.
// Assumes one AHB-Lite master and word transfers; oscillator inputs are resynced to clk_i.
//
// Notes on behaviour
// RL1 - With split mode off, both count bytes form one 16-bit up-counter that reloads automatically.
// RL2 - In 16-bit mode a roll from FFFF to 0000 loads both reload bytes into the counter and sets the high flag.
// RL3 - In 16-bit mode every full overflow requests an interrupt when the timer interrupt enable is set.
// RL4 - In 16-bit mode with the low-byte interrupt enable also set, each low-byte roll requests an interrupt.
// RL5 - Count clocks are the system clock, the system clock over 12 and the external oscillator over 8, resynced.
// RL6 - With split mode on, two 8-bit counters each reload from their own reload byte on overflow.
// RL7 - In split mode the run bit gates only the high byte, and the low byte always counts.
// RL8 - In split mode the high byte uses its clock select and the external select to pick its clock.
// RL9 - In split mode the low byte picks its clock the same way with its own clock select.
// RL10 - The high flag sets when the high byte rolls FF to 00, the low flag when the low byte does.
// RL11 - In split mode a high overflow requests an interrupt, and with low enable set so does a low one.
// RL12 - Hardware never clears either overflow flag; only a software write of zero does.
// RL13 - Software reads both flags to find the interrupt source and then clears them.
// RL14 - With capture and interrupts enabled in 16-bit mode, each rising low-frequency edge copies the count into reload.
// RL15 - In 16-bit mode the run bit starts the whole counter when set and stops it when clear.
`include "timer3_defines.svh"
`default_nettype none

module timer3_auto_reload_timer #(
    parameter int DIV_SYS = `TIM3_DIV_SYS,
    parameter int DIV_EXT = `TIM3_DIV_EXT
) (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o,
    input  wire logic        ext_osc_i,
    input  wire logic        lfo_i,
    output logic             irq_o
);

    // ==========================================================
    // Elaboration checks
    localparam int PW = (DIV_SYS > 1) ? $clog2(DIV_SYS) : 1;
    localparam int EW = (DIV_EXT > 1) ? $clog2(DIV_EXT) : 1;
    localparam logic [PW-1:0] PRE_LAST = PW'(DIV_SYS - 1);
    localparam logic [EW-1:0] EXT_LAST = EW'(DIV_EXT - 1);

    // Refused at elaboration: a ratio below two leaves no counter to build
    if (DIV_SYS < 2 || DIV_EXT < 2)
    begin : g_bad_div
        $error("Divider ratios must be at least two");
    end

    // ==========================================================
    // Bus address phase capture
    logic                     dp_valid_q;
    logic                     dp_write_q;
    logic [`TIM3_ADDR_W-1:0]  dp_addr_q;
    wire                      addr_take = hsel_i & hready_i & htrans_i[1];

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_addr_q  <= '0;
        end
        else
        begin
            dp_valid_q <= addr_take & (hsize_i == `TIM3_HSIZE_WORD);
            dp_write_q <= hwrite_i;
            dp_addr_q  <= haddr_i[`TIM3_ADDR_W-1:0];
        end
    end

    // Write strobes in the data phase
    wire dp_wr   = dp_valid_q & dp_write_q;
    wire wr_ctrl = dp_wr & (dp_addr_q == `TIM3_OFF_CTRL);
    wire wr_rll  = dp_wr & (dp_addr_q == `TIM3_OFF_RLL);
    wire wr_rlh  = dp_wr & (dp_addr_q == `TIM3_OFF_RLH);
    wire wr_cntl = dp_wr & (dp_addr_q == `TIM3_OFF_CNTL);
    wire wr_cnth = dp_wr & (dp_addr_q == `TIM3_OFF_CNTH);
    wire wr_cfg  = dp_wr & (dp_addr_q == `TIM3_OFF_CFG);
    wire [7:0] wbyte = hwdata_i[7:0];

    // ==========================================================
    // Timer state
    logic [7:0]             ctrl_q, ctrl_d;
    logic [`TIM3_CFG_W-1:0] cfg_q, cfg_d;
    logic [7:0]             count_low_byte_q, count_low_byte_d;
    logic [7:0]             count_high_byte_q, count_high_byte_d;
    logic [7:0]             reload_low_byte_q, reload_low_byte_d;
    logic [7:0]             reload_high_byte_q, reload_high_byte_d;

    wire high_overflow_flag      = ctrl_q[`TIM3_CTRL_TFH];
    wire low_overflow_flag       = ctrl_q[`TIM3_CTRL_TFL];
    wire low_overflow_irq_enable = ctrl_q[`TIM3_CTRL_LEN];
    wire lfo_capture_enable      = ctrl_q[`TIM3_CTRL_CEN];
    wire split_mode_select       = ctrl_q[`TIM3_CTRL_SPLIT];
    wire run_control             = ctrl_q[`TIM3_CTRL_RUN];
    wire external_clock_select   = ctrl_q[`TIM3_CTRL_XCLK];
    wire low_byte_clock_select   = cfg_q[`TIM3_CFG_LCS];
    wire high_byte_clock_select  = cfg_q[`TIM3_CFG_HCS];
    wire timer_irq_enable        = cfg_q[`TIM3_CFG_IE];
    wire [15:0] count_word       = {count_high_byte_q, count_low_byte_q};
    wire [15:0] reload_word      = {reload_high_byte_q, reload_low_byte_q};

    // ==========================================================
    // Clock sources: prescaler and resynced external/LFO edges
    logic [PW-1:0] prescale_q;
    logic [EW-1:0] ext_cnt_q;
    logic [2:0]    ext_sync_q;
    logic [2:0]    lfo_sync_q;

    // Stage 0 feeds only stage 1; edges come from stages 1 and 2
    wire ext_rise  = ext_sync_q[1] & ~ext_sync_q[2];
    wire lfo_rise  = lfo_sync_q[1] & ~lfo_sync_q[2];
    wire tick_div  = (prescale_q == PRE_LAST);                  // see RL5
    wire tick_ext  = ext_rise & (ext_cnt_q == EXT_LAST);        // see RL5

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            prescale_q <= '0;
            ext_cnt_q  <= '0;
            ext_sync_q <= '0;
            lfo_sync_q <= '0;
        end
        else
        begin
            prescale_q <= tick_div ? '0 : prescale_q + PW'(1);
            ext_cnt_q  <= ext_rise ? ext_cnt_q + EW'(1) : ext_cnt_q;
            ext_sync_q <= {ext_sync_q[1:0], ext_osc_i};
            lfo_sync_q <= {lfo_sync_q[1:0], lfo_i};
        end
    end

    // Per-byte source choice; 16-bit mode counts on the low byte's clock
    wire timer3_pkg::clk_src_t low_src  = low_byte_clock_select ? timer3_pkg::CLK_SYS :
        (external_clock_select ? timer3_pkg::CLK_EXT8 : timer3_pkg::CLK_DIV12);      // see RL9
    wire timer3_pkg::clk_src_t high_src = high_byte_clock_select ? timer3_pkg::CLK_SYS :
        (external_clock_select ? timer3_pkg::CLK_EXT8 : timer3_pkg::CLK_DIV12);      // see RL8

    function automatic logic tick_of(input timer3_pkg::clk_src_t src, input logic div, input logic ext);
        unique case (src)
            timer3_pkg::CLK_SYS:   tick_of = 1'b1;
            timer3_pkg::CLK_DIV12: tick_of = div;
            timer3_pkg::CLK_EXT8:  tick_of = ext;
            default:               tick_of = 1'b0;
        endcase
    endfunction : tick_of

    wire tick_lo = tick_of(low_src, tick_div, tick_ext);
    wire tick_hi = tick_of(high_src, tick_div, tick_ext);

    // Capture only in 16-bit mode with interrupts on
    wire capture = lfo_capture_enable & timer_irq_enable & lfo_rise & ~split_mode_select;  // see RL14

    // ==========================================================
    // Next-state of counters, reloads and flags
    logic set_high;
    logic set_low;

    always_comb
    begin
        count_low_byte_d   = count_low_byte_q;
        count_high_byte_d  = count_high_byte_q;
        reload_low_byte_d  = reload_low_byte_q;
        reload_high_byte_d = reload_high_byte_q;
        set_high           = 1'b0;
        set_low            = 1'b0;
        if (split_mode_select)
        begin
            if (tick_lo)                                        // see RL7
            begin
                if (count_low_byte_q == `TIM3_BYTE_MAX)
                begin
                    count_low_byte_d = reload_low_byte_q;       // see RL6
                    set_low          = 1'b1;                    // see RL10
                end
                else
                begin
                    count_low_byte_d = count_low_byte_q + 8'h01;
                end
            end
            if (run_control && tick_hi)                         // see RL7
            begin
                if (count_high_byte_q == `TIM3_BYTE_MAX)
                begin
                    count_high_byte_d = reload_high_byte_q;     // see RL6
                    set_high          = 1'b1;                   // see RL10
                end
                else
                begin
                    count_high_byte_d = count_high_byte_q + 8'h01;
                end
            end
        end
        else if (run_control && tick_lo)                        // see RL15
        begin
            set_low = (count_low_byte_q == `TIM3_BYTE_MAX);     // see RL10
            if (count_word == `TIM3_WORD_MAX)
            begin
                {count_high_byte_d, count_low_byte_d} = reload_word;  // see RL2
                set_high = 1'b1;                                // see RL2
            end
            else
            begin
                {count_high_byte_d, count_low_byte_d} = count_word + 16'h0001;  // see RL1
            end
        end
        if (capture)
        begin
            {reload_high_byte_d, reload_low_byte_d} = count_word;   // see RL14
        end
        // Software writes win over counting and capture
        if (wr_cntl)
        begin
            count_low_byte_d = wbyte;
        end
        if (wr_cnth)
        begin
            count_high_byte_d = wbyte;
        end
        if (wr_rll)
        begin
            reload_low_byte_d = wbyte;
        end
        if (wr_rlh)
        begin
            reload_high_byte_d = wbyte;
        end
    end

    // Control: a hardware set beats a clearing write in the same cycle
    always_comb
    begin
        ctrl_d = wr_ctrl ? (wbyte & `TIM3_CTRL_WMASK) : ctrl_q;
        ctrl_d[`TIM3_CTRL_TFH] = set_high | (wr_ctrl ? wbyte[`TIM3_CTRL_TFH] : high_overflow_flag);  // see RL12
        ctrl_d[`TIM3_CTRL_TFL] = set_low | (wr_ctrl ? wbyte[`TIM3_CTRL_TFL] : low_overflow_flag);    // see RL12
        cfg_d  = wr_cfg ? wbyte[`TIM3_CFG_W-1:0] : cfg_q;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ctrl_q             <= `TIM3_CTRL_RESET;
            cfg_q              <= `TIM3_CFG_RESET;
            count_low_byte_q   <= `TIM3_BYTE_RESET;
            count_high_byte_q  <= `TIM3_BYTE_RESET;
            reload_low_byte_q  <= `TIM3_BYTE_RESET;
            reload_high_byte_q <= `TIM3_BYTE_RESET;
        end
        else
        begin
            ctrl_q             <= ctrl_d;
            cfg_q              <= cfg_d;
            count_low_byte_q   <= count_low_byte_d;
            count_high_byte_q  <= count_high_byte_d;
            reload_low_byte_q  <= reload_low_byte_d;
            reload_high_byte_q <= reload_high_byte_d;
        end
    end

    // ==========================================================
    // Interrupt request and read-back
    // Same form in both modes; handler sorts the source out from the flags (see RL13)
    assign irq_o = timer_irq_enable &
                   (high_overflow_flag | (low_overflow_irq_enable & low_overflow_flag));  // see RL3 see RL4 see RL11

    // Read mux of next-state values, registered at the address edge, so the data
    // phase shows the live register from a flop; unmapped offsets read zero
    wire [`TIM3_ADDR_W-1:0] rd_addr = haddr_i[`TIM3_ADDR_W-1:0];
    wire                    rd_take = addr_take & ~hwrite_i & (hsize_i == `TIM3_HSIZE_WORD);
    wire [7:0] rd_byte =
        (rd_addr == `TIM3_OFF_CTRL) ? ctrl_d :
        (rd_addr == `TIM3_OFF_RLL)  ? reload_low_byte_d :
        (rd_addr == `TIM3_OFF_RLH)  ? reload_high_byte_d :
        (rd_addr == `TIM3_OFF_CNTL) ? count_low_byte_d :
        (rd_addr == `TIM3_OFF_CNTH) ? count_high_byte_d :
        (rd_addr == `TIM3_OFF_CFG)  ? {5'h00, cfg_d} : 8'h00;
    logic [31:0] hrdata_q;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            hrdata_q <= 32'h00000000;
        end
        else
        begin
            hrdata_q <= rd_take ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    assign hrdata_o    = hrdata_q;
    assign hreadyout_o = 1'b1;       // Zero wait states, so no stall path is needed
    assign hresp_o     = `TIM3_HRESP_OKAY;

    // ==========================================================
    // Checks
    wire sw_count = wr_cntl | wr_cnth | wr_rll | wr_rlh;

    wrap_reload_a: assert property (@(posedge clk_i) disable iff (!resetn_i)  // see RL2
        !split_mode_select && run_control && tick_lo && count_word == `TIM3_WORD_MAX && !sw_count && !capture
        |=> count_word == $past(reload_word) && high_overflow_flag)
        else $error("16-bit wrap did not reload or flag");

    flag_sticky_a: assert property (@(posedge clk_i) disable iff (!resetn_i)  // see RL12
        high_overflow_flag && low_overflow_flag && !wr_ctrl |=> high_overflow_flag && low_overflow_flag)
        else $error("Overflow flag cleared without a write");

    high_gated_a: assert property (@(posedge clk_i) disable iff (!resetn_i)  // see RL7
        split_mode_select && !run_control && !wr_cnth |=> $stable(count_high_byte_q))
        else $error("Stopped high byte moved");

    low_free_a: assert property (@(posedge clk_i) disable iff (!resetn_i)  // see RL7
        split_mode_select && !run_control && tick_lo && count_low_byte_q != `TIM3_BYTE_MAX && !wr_cntl
        |=> count_low_byte_q == $past(count_low_byte_q) + 8'h01)
        else $error("Low byte did not count in split mode");

    stop_word_a: assert property (@(posedge clk_i) disable iff (!resetn_i)  // see RL15
        !split_mode_select && !run_control && !sw_count |=> $stable(count_word))
        else $error("Stopped 16-bit counter moved");

    low_flag_a: assert property (@(posedge clk_i) disable iff (!resetn_i)  // see RL10 see RL6
        split_mode_select && tick_lo && count_low_byte_q == `TIM3_BYTE_MAX && !wr_cntl && !wr_ctrl
        |=> low_overflow_flag && count_low_byte_q == $past(reload_low_byte_q))
        else $error("Low byte overflow missed");

    irq_follow_a: assert property (@(posedge clk_i) disable iff (!resetn_i)  // see RL4 see RL11
        set_low && low_overflow_irq_enable && timer_irq_enable && !wr_ctrl && !wr_cfg |=> irq_o)
        else $error("Low overflow raised no request");

    div_gap_a: assert property (@(posedge clk_i) disable iff (!resetn_i)  // see RL5
        tick_div |=> !tick_div [*8])
        else $error("Divide-by-12 tick came too soon");

    high_div_a: assert property (@(posedge clk_i) disable iff (!resetn_i)  // see RL8
        split_mode_select && run_control && !high_byte_clock_select && !external_clock_select
        && !tick_div && !wr_cnth |=> $stable(count_high_byte_q))
        else $error("High byte counted without its divided tick");

    low_ext_a: assert property (@(posedge clk_i) disable iff (!resetn_i)  // see RL9
        split_mode_select && !low_byte_clock_select && external_clock_select && !tick_ext && !wr_cntl
        |=> $stable(count_low_byte_q))
        else $error("Low byte counted without its external tick");

    capture_a: assert property (@(posedge clk_i) disable iff (!resetn_i)  // see RL14
        capture && !wr_rll && !wr_rlh |=> reload_word == $past(count_word))
        else $error("Low-frequency capture missed");

endmodule : timer3_auto_reload_timer

`default_nettype wire

/* timer3_defines.svh */
// Constants for the 16-bit auto-reload timer: offsets, field positions, resets.
// Assumes inclusion by bare name from the timer module.
`ifndef TIMER3_DEFINES_SVH
`define TIMER3_DEFINES_SVH

// ==========================================================
// Register byte offsets on the AHB-Lite bus
`define TIM3_ADDR_W        8
`define TIM3_OFF_CTRL      8'h00
`define TIM3_OFF_RLL       8'h04
`define TIM3_OFF_RLH       8'h08
`define TIM3_OFF_CNTL      8'h0C
`define TIM3_OFF_CNTH      8'h10
`define TIM3_OFF_CFG       8'h14

// ==========================================================
// Control register fields
`define TIM3_CTRL_TFH      7
`define TIM3_CTRL_TFL      6
`define TIM3_CTRL_LEN      5
`define TIM3_CTRL_CEN      4
`define TIM3_CTRL_SPLIT    3
`define TIM3_CTRL_RUN      2
`define TIM3_CTRL_XCLK     0
`define TIM3_CTRL_WMASK    8'hFD
`define TIM3_CTRL_RESET    8'h00

// ==========================================================
// Configuration register fields (clock selects, timer interrupt enable)
`define TIM3_CFG_W         3
`define TIM3_CFG_LCS       0
`define TIM3_CFG_HCS       1
`define TIM3_CFG_IE        2
`define TIM3_CFG_RESET     3'h0

// ==========================================================
// Counting constants and bus codes
`define TIM3_BYTE_RESET    8'h00
`define TIM3_BYTE_MAX      8'hFF
`define TIM3_WORD_MAX      16'hFFFF
`define TIM3_DIV_SYS       12
`define TIM3_DIV_EXT       8
`define TIM3_HSIZE_WORD    3'h2
`define TIM3_HRESP_OKAY    1'h0

`endif

/* timer3_pkg.sv */
// Types shared by the auto-reload timer.
// Assumes the defines header is on the include path.
`default_nettype none

package timer3_pkg;
    // Count clock source of one counter byte
    typedef enum logic [1:0] {
        CLK_SYS   = 2'b00,
        CLK_DIV12 = 2'b01,
        CLK_EXT8  = 2'b10
    } clk_src_t;
endpackage : timer3_pkg

`default_nettype wire

/* HANDOVER_unused_marker.sv */
`default_nettype none
`default_nettype wire

/* timer3_auto_reload_timer_test.sv */
// Self-checking bench for the auto-reload timer: AHB-Lite register access, both modes, clocks, capture.
// Assumes the timer's zero-wait-state slave and a 250 MHz system clock made here.
`default_nettype none

module timer3_auto_reload_timer_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Signals
    logic        clk_i     = 1'b0;
    logic        resetn_i  = 1'b0;
    logic        hsel_i    = 1'b0;
    logic [31:0] haddr_i   = 32'h0;
    logic [1:0]  htrans_i  = 2'h0;
    logic        hwrite_i  = 1'b0;
    logic [2:0]  hsize_i   = 3'h2;
    logic [31:0] hwdata_i  = 32'h0;
    logic        ext_osc_i = 1'b0;
    logic        lfo_i     = 1'b0;
    wire logic   hreadyout_o;
    wire logic   hresp_o;
    wire logic [31:0] hrdata_o;
    wire logic   irq_o;
    logic [31:0] rd;
    logic [15:0] v;
    logic [2:0]  sz        = 3'h2;
    int          bad_count = 0;
    int          checked   = 0;
    int          seed      = 13;
    int          n;

    // Free-running system clock, 4 ns period
    always #2 clk_i = ~clk_i;

    timer3_auto_reload_timer i_dut (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .hsel_i      (hsel_i),
        .haddr_i     (haddr_i),
        .htrans_i    (htrans_i),
        .hwrite_i    (hwrite_i),
        .hsize_i     (hsize_i),
        .hwdata_i    (hwdata_i),
        .hready_i    (hreadyout_o),
        .hreadyout_o (hreadyout_o),
        .hresp_o     (hresp_o),
        .hrdata_o    (hrdata_o),
        .ext_osc_i   (ext_osc_i),
        .lfo_i       (lfo_i),
        .irq_o       (irq_o)
    );

    // ==========================================================
    // Reference model: count after k ticks, wrapping to the reload value
    function automatic int stepn(int val, int rl, int top, int k);
        for (int i = 0; i < k; i++)
            val = (val == top) ? rl : val + 1;
        return val;
    endfunction : stepn

    // ==========================================================
    // Checks and bus cycles; every task but check is entered just after a rising edge
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
        hsel_i   <= 1'b1;
        haddr_i  <= {24'h000000, a};
        htrans_i <= 2'h2;
        hwrite_i <= wr_en;
        hsize_i  <= sz;
        @(posedge clk_i);
        while (hreadyout_o !== 1'b1)
            @(posedge clk_i);
        hsel_i   <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        @(posedge clk_i);
        while (hreadyout_o !== 1'b1)
            @(posedge clk_i);
        rd = hrdata_o; // Pre-edge value: flops of this edge have not landed yet
        check({31'h0, hresp_o}, 32'h0, "okay response");
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string what);
        bus(1'b0, a, 32'h0);
        check(rd, e, what);
    endtask : rdc

    task automatic rd16(output logic [15:0] val);
        bus(1'b0, 8'h0C, 32'h0);
        val[7:0] = rd[7:0];
        bus(1'b0, 8'h10, 32'h0);
        val[15:8] = rd[7:0];
    endtask : rd16

    // Start latency is one tick uncertain, so a window of three tick counts is accepted
    task automatic near(input logic [15:0] got, input int st, input int rl, input int top, input int k,
                        input string what);
        logic ok;
        ok = 1'b0;
        for (int j = k - 1; j <= k + 1; j++)
            if (got === 16'(stepn(st, rl, top, j)))
                ok = 1'b1;
        check({31'h0, ok}, 32'h1, what);
    endtask : near

    // Interrupt is combinational from flops, so it is looked at mid-cycle
    task automatic irq_is(input logic e, input string what);
        @(negedge clk_i);
        check({31'h0, irq_o}, {31'h0, e}, what);
        @(posedge clk_i);
    endtask : irq_is

    task automatic end_of_test();
        $display("Summary: %0d comparisons, %0d mismatches", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    // ==========================================================
    // Watchdog, far beyond the several hundred cycles the sequence needs
    initial
    begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        end_of_test();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        // Reset values, unmapped offset 0x18, read-only bit 1, ignored byte-size write
        for (int a = 0; a <= 8'h18; a += 4)
            rdc(8'(a), 32'h0, "reset value"); // see timer_three_control
        wr(8'h00, 32'h02);
        rdc(8'h00, 32'h0, "unused control bit");
        sz = 3'h0;
        wr(8'h04, 32'h55);
        sz = 3'h2;
        rdc(8'h04, 32'h0, "non-word write");
        // 16-bit mode roll FFFF to 0000 with reload 1234
        wr(8'h14, 32'h05);
        wr(8'h04, 32'h34);
        wr(8'h08, 32'h12);
        wr(8'h0C, 32'hFE);
        wr(8'h10, 32'hFF);
        irq_is(1'b0, "idle interrupt");
        wr(8'h00, 32'h04);
        repeat (8) @(posedge clk_i);
        rdc(8'h00, 32'hC4, "flags on full roll");
        irq_is(1'b1, "full overflow interrupt");
        repeat (20) @(posedge clk_i);
        rdc(8'h00, 32'hC4, "flags stay set");
        wr(8'h00, 32'h00);
        rdc(8'h00, 32'h00, "flags cleared by write");
        irq_is(1'b0, "interrupt after clear");
        rd16(v);
        near(v, 16'hFFFE, 16'h1234, 16'hFFFF, 35, "16-bit count");
        repeat (10) @(posedge clk_i);
        rd16(rd[15:0]);
        check({16'h0, rd[15:0]}, {16'h0, v}, "stopped count");
        // Low byte roll in 16-bit mode; both flags read to find the source
        wr(8'h0C, 32'hFD);
        wr(8'h10, 32'h00);
        wr(8'h04, 32'h00);
        wr(8'h08, 32'h00);
        wr(8'h00, 32'h04);
        repeat (4) @(posedge clk_i);
        rdc(8'h00, 32'h44, "low flag only");
        irq_is(1'b0, "low roll, low enable off");
        wr(8'h00, 32'h64);
        irq_is(1'b1, "low roll, low enable on");
        wr(8'h00, 32'h00);
        irq_is(1'b0, "low flag cleared");
        // Split mode: low byte runs with run bit clear, high byte held
        wr(8'h14, 32'h07);
        wr(8'h04, 32'h80);
        wr(8'h08, 32'h20);
        wr(8'h0C, 32'hFE);
        wr(8'h10, 32'h10);
        wr(8'h00, 32'h08);
        repeat (6) @(posedge clk_i);
        rdc(8'h00, 32'h48, "split low flag");
        irq_is(1'b0, "split low, low enable off");
        wr(8'h00, 32'h00);
        rd16(v);
        near({8'h00, v[7:0]}, 8'hFE, 8'h80, 8'hFF, 11, "split low reload");
        check({24'h0, v[15:8]}, 32'h10, "high byte held");
        wr(8'h10, 32'hFF);
        wr(8'h00, 32'h0C);
        repeat (4) @(posedge clk_i);
        rdc(8'h00, 32'h8C, "split high flag");
        irq_is(1'b1, "split high interrupt");
        wr(8'h00, 32'h00);
        rd16(v);
        near({8'h00, v[15:8]}, 8'hFF, 8'h20, 8'hFF, 9, "split high reload");
        // Clock select table: one byte on the system clock, the other on the /12 tick
        for (int i = 0; i < 2; i++)
        begin
            wr(8'h0C, 32'h0);
            wr(8'h10, 32'h0);
            wr(8'h14, i ? 32'h06 : 32'h05);
            wr(8'h00, 32'h0C);
            repeat (118) @(posedge clk_i);
            wr(8'h00, 32'h00);
            rd16(v);
            near({8'h00, v[7:0]}, 0, 0, 255, i ? 10 : 120, "low byte clock");
            near({8'h00, v[15:8]}, 0, 0, 255, i ? 120 : 10, "high byte clock");
        end
        // External oscillator over 8, random whole number of groups of eight edges
        n = 8 * (2 + ($random(seed) & 3));
        wr(8'h0C, 32'h0);
        wr(8'h10, 32'h0);
        wr(8'h14, 32'h04);
        wr(8'h00, 32'h0D);
        repeat (n)
        begin
            ext_osc_i <= 1'b1;
            repeat (2) @(posedge clk_i);
            ext_osc_i <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
        repeat (4) @(posedge clk_i);
        wr(8'h00, 32'h00);
        rd16(v);
        near({8'h00, v[7:0]}, 0, 0, 255, n / 8, "low byte external");
        near({8'h00, v[15:8]}, 0, 0, 255, n / 8, "high byte external");
        // Capture into reload on a slow-oscillator edge, only with interrupts enabled
        wr(8'h0C, 32'hCD);
        wr(8'h10, 32'hAB);
        wr(8'h00, 32'h10);
        for (int i = 0; i < 2; i++)
        begin
            wr(8'h14, i ? 32'h00 : 32'h04);
            wr(8'h0C, i ? 32'h5A : 32'hCD);
            lfo_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            lfo_i <= 1'b0;
            repeat (2) @(posedge clk_i);
            rdc(8'h04, 32'hCD, "captured low");
            rdc(8'h08, 32'hAB, "captured high");
        end
        end_of_test();
    end

endmodule : timer3_auto_reload_timer_test

`default_nettype wire
